//--- common/ascx_defines.svh
// Constants for the ALU slice carry and status expansion block
`ifndef ASCX_DEFINES_SVH
`define ASCX_DEFINES_SVH

`define ASCX_WIDTH 4
`define ASCX_MSB 3
`define ASCX_ADDR_W 3
`define ASCX_DEPTH 8
`define ASCX_OP_W 3

// Operation codes on {high, mid, low} select bits
`define ASCX_OP_ADD_INC 3'h0
`define ASCX_OP_ADD 3'h1
`define ASCX_OP_AND 3'h2
`define ASCX_OP_PASS_BUS 3'h3
`define ASCX_OP_PASS_REG 3'h4
`define ASCX_OP_OR 3'h5
`define ASCX_OP_XOR 3'h6
`define ASCX_OP_INV_BUS 3'h7

// Upper select field value that marks arithmetic
`define ASCX_ARITH_FIELD 2'h0

// Reset values
`define ASCX_RAM_RST 4'h0
`define ASCX_OUT_N_RST 4'hF
`define ASCX_NIB_ZERO 4'h0

`endif

//--- common/ascx_pkg.sv
// Types shared by the ALU slice design files
`default_nettype none
package ascx_pkg;
	`include "ascx_defines.svh"

	typedef logic [`ASCX_WIDTH-1:0] ascx_nib_t;
	typedef logic [`ASCX_ADDR_W-1:0] ascx_addr_t;
	typedef logic [`ASCX_OP_W-1:0] ascx_op_t;

	// Clock pulse pin phase tracker, one-hot
	typedef enum logic [1:0] {
		ASCX_CP_LOW = 2'b01,
		ASCX_CP_HIGH = 2'b10
	} ascx_cp_state_t;
endpackage
`default_nettype wire

//--- design/ascx_alu4.sv
// Four-bit ALU core with group carry propagate, generate and overflow
`default_nettype none
`include "ascx_defines.svh"
module ascx_alu4 import ascx_pkg::*; (
	input wire ascx_nib_t opnd_reg,
	input wire ascx_nib_t opnd_bus,
	input wire ascx_op_t op_code,
	input wire logic carry_in,
	output ascx_nib_t result,
	output logic carry_out,
	output logic grp_prop,
	output logic grp_gen,
	output logic ovf,
	output logic is_arith
);
	// Five-bit sum of two nibbles and a carry
	function automatic logic [`ASCX_WIDTH:0] add_nib(input ascx_nib_t a, input ascx_nib_t b, input logic c);
		add_nib = {1'b0, a} + {1'b0, b} + {{`ASCX_WIDTH{1'b0}}, c};
	endfunction

	// Group generate of the 4-bit lookahead tree
	function automatic logic group_gen(input ascx_nib_t g, input ascx_nib_t p);
		group_gen = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]);
	endfunction

	wire logic [`ASCX_WIDTH:0] sum_w;
	wire ascx_nib_t bit_gen;
	wire ascx_nib_t bit_prop;
	wire logic same_sign;

	// Only the two codes with both upper bits low add
	assign is_arith = (op_code[`ASCX_OP_W-1:1] == `ASCX_ARITH_FIELD);
	assign sum_w = add_nib(opnd_reg, opnd_bus, carry_in);
	assign bit_gen = opnd_reg & opnd_bus;
	assign bit_prop = opnd_reg | opnd_bus;
	assign grp_prop = &bit_prop;
	assign grp_gen = group_gen(bit_gen, bit_prop);
	assign carry_out = sum_w[`ASCX_WIDTH];

	// Overflow: equal operand signs, result sign differs; arithmetic only
	assign same_sign = ~(opnd_reg[`ASCX_MSB] ^ opnd_bus[`ASCX_MSB]);
	assign ovf = is_arith & same_sign & (sum_w[`ASCX_MSB] ^ opnd_reg[`ASCX_MSB]);

	// Function select
	always_comb begin
		case (op_code)
			`ASCX_OP_ADD_INC: result = sum_w[`ASCX_MSB:0];
			`ASCX_OP_ADD: result = sum_w[`ASCX_MSB:0];
			`ASCX_OP_AND: result = opnd_reg & opnd_bus;
			`ASCX_OP_PASS_BUS: result = opnd_bus;
			`ASCX_OP_PASS_REG: result = opnd_reg;
			`ASCX_OP_OR: result = opnd_reg | opnd_bus;
			`ASCX_OP_XOR: result = opnd_reg ^ opnd_bus;
			`ASCX_OP_INV_BUS: result = ~opnd_bus;
			default: result = `ASCX_NIB_ZERO;
		endcase
	end
endmodule
`default_nettype wire

//--- design/ascx_slice.sv
// ALU register-stack slice with carry expansion and status outputs
`default_nettype none
`include "ascx_defines.svh"

module ascx_slice import ascx_pkg::*; (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [3:0] DATA_IN_N,
	input wire logic [2:0] ADDR_SEL,
	input wire logic CARRY_IN_OR_OP_BIT,
	input wire logic OP_SELECT_MID,
	input wire logic OP_SELECT_HIGH,
	input wire logic TOP_SLICE_SELECT,
	input wire logic CLOCK_PULSE_IN,
	input wire logic EXECUTE_GATE_N,
	input wire logic OUTPUT_DRIVE_ENABLE_N,
	output logic [3:0] DATA_OUT_N,
	output logic DATA_OUT_OE,
	output logic RIPPLE_CARRY_N,
	output logic PROPAGATE_N,
	output logic GENERATE_N,
	output logic ZERO_FLAG_O,
	output logic ZERO_FLAG_OE
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the microcycle controls
	////////////////////////////////////////////////////////////////////////////

	logic cp_meta_q;
	logic cp_sync_q;
	logic ex_n_meta_q;
	logic ex_n_sync_q;
	logic eo_n_meta_q;
	logic eo_n_sync_q;

	// Two stages each; only the second stage feeds logic
	always_ff @(posedge MCLK) begin
		if (RST) begin
			cp_meta_q <= 1'b0;
			cp_sync_q <= 1'b0;
			ex_n_meta_q <= 1'b1;
			ex_n_sync_q <= 1'b1;
			eo_n_meta_q <= 1'b1;
			eo_n_sync_q <= 1'b1;
		end else begin
			cp_meta_q <= CLOCK_PULSE_IN;
			cp_sync_q <= cp_meta_q;
			ex_n_meta_q <= EXECUTE_GATE_N;
			ex_n_sync_q <= ex_n_meta_q;
			eo_n_meta_q <= OUTPUT_DRIVE_ENABLE_N;
			eo_n_sync_q <= eo_n_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock pulse phase tracker
	////////////////////////////////////////////////////////////////////////////

	ascx_cp_state_t cp_state_q;
	ascx_cp_state_t cp_state_d;
	wire logic cp_rise;

	// Low-to-high pulse edge starts a new microcycle
	always_comb begin
		case (cp_state_q)
			ASCX_CP_LOW: cp_state_d = cp_sync_q ? ASCX_CP_HIGH : ASCX_CP_LOW;
			ASCX_CP_HIGH: cp_state_d = cp_sync_q ? ASCX_CP_HIGH : ASCX_CP_LOW;
			default: cp_state_d = ASCX_CP_LOW;
		endcase
	end

	// Reset to the high phase; the synchroniser resets low, so a pin held high at release still gives one edge
	always_ff @(posedge MCLK) begin
		if (RST) begin
			cp_state_q <= ASCX_CP_HIGH;
		end else begin
			cp_state_q <= cp_state_d;
		end
	end

	// One-cycle strobe on the synced pulse edge
	assign cp_rise = (cp_state_q == ASCX_CP_LOW) & cp_sync_q;

	////////////////////////////////////////////////////////////////////////////
	// Operand store and operand selection
	////////////////////////////////////////////////////////////////////////////

	ascx_nib_t ram_q [0:`ASCX_DEPTH-1];
	wire ascx_nib_t opnd_reg;
	wire ascx_nib_t opnd_bus;
	wire ascx_op_t op_code;
	wire logic carry_in;

	// Read is live from the select pins so the status paths stay combinational
	assign opnd_reg = ram_q[ADDR_SEL];
	assign opnd_bus = ~DATA_IN_N;
	assign op_code = {OP_SELECT_HIGH, OP_SELECT_MID, CARRY_IN_OR_OP_BIT};

	// Carry-in is active low, the same sense as the ripple carry out
	assign carry_in = ~CARRY_IN_OR_OP_BIT;

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic core
	////////////////////////////////////////////////////////////////////////////

	wire ascx_nib_t alu_result;
	wire logic alu_cout;
	wire logic alu_prop;
	wire logic alu_gen;
	wire logic alu_ovf;
	wire logic alu_arith;

	ascx_alu4 u_alu (
		.opnd_reg(opnd_reg),
		.opnd_bus(opnd_bus),
		.op_code(op_code),
		.carry_in(carry_in),
		.result(alu_result),
		.carry_out(alu_cout),
		.grp_prop(alu_prop),
		.grp_gen(alu_gen),
		.ovf(alu_ovf),
		.is_arith(alu_arith)
	);

	////////////////////////////////////////////////////////////////////////////
	// Expansion outputs
	////////////////////////////////////////////////////////////////////////////

	wire logic ripple_n;
	wire logic prop_n;
	wire logic gen_n;
	wire logic negative;
	wire logic stat_neg_n;
	wire logic stat_ovf_n;
	wire logic la_prop_n;
	wire logic la_gen_n;

	// Carry out in arithmetic, instruction pass-through otherwise
	assign ripple_n = alu_arith ? ~alu_cout : CARRY_IN_OR_OP_BIT;

	// Sign of the result marks a negative answer on the top slice
	assign negative = alu_result[`ASCX_MSB];
	assign stat_neg_n = ~negative;
	assign stat_ovf_n = ~alu_ovf;

	// Lesser slices: live terms in arithmetic, pass-through pattern so lookahead forwards the op bit
	assign la_prop_n = alu_arith ? ~alu_prop : 1'b0;
	assign la_gen_n = alu_arith ? ~alu_gen : 1'b1;

	// Top slice shows status; lesser slices show lookahead terms
	assign prop_n = TOP_SLICE_SELECT ? stat_neg_n : la_prop_n;
	assign gen_n = TOP_SLICE_SELECT ? stat_ovf_n : la_gen_n;

	// Not registered: neighbours and the lookahead need them within the cycle
	always_comb begin
		RIPPLE_CARRY_N = ripple_n;
		PROPAGATE_N = prop_n;
		GENERATE_N = gen_n;
	end

	////////////////////////////////////////////////////////////////////////////
	// Zero status, open drain
	////////////////////////////////////////////////////////////////////////////

	wire logic result_nonzero;

	// Any set bit pulls the shared line low; all slices zero lets it float high
	assign result_nonzero = |alu_result;

	always_comb begin
		ZERO_FLAG_O = 1'b0; // Open drain only ever sinks
		ZERO_FLAG_OE = result_nonzero;
	end

	////////////////////////////////////////////////////////////////////////////
	// Microcycle commit: store write-back and output register
	////////////////////////////////////////////////////////////////////////////

	wire logic commit;
	wire ascx_nib_t result_pin_n;
	ascx_nib_t out_n_q;
	logic out_oe_q;

	// Execute high still computes, but nothing is stored
	assign commit = cp_rise & ~ex_n_sync_q;

	// Pin polarity of the result, taken only at a commit
	assign result_pin_n = ~alu_result;

	// Store write-back of the result into the selected word
	always_ff @(posedge MCLK) begin
		if (RST) begin
			for (int i = 0; i < `ASCX_DEPTH; i++) begin
				ram_q[i] <= `ASCX_RAM_RST;
			end
		end else if (commit) begin
			ram_q[ADDR_SEL] <= alu_result;
		end
	end

	// Output register holds the result in pin polarity
	always_ff @(posedge MCLK) begin
		if (RST) begin
			out_n_q <= `ASCX_OUT_N_RST;
		end else if (commit) begin
			out_n_q <= result_pin_n;
		end
	end

	// Data pin drive enable follows the synced active-low enable
	always_ff @(posedge MCLK) begin
		if (RST) begin
			out_oe_q <= 1'b0;
		end else begin
			out_oe_q <= ~eo_n_sync_q;
		end
	end

	// Data pins straight from their registers
	assign DATA_OUT_N = out_n_q;
	assign DATA_OUT_OE = out_oe_q;

endmodule
`default_nettype wire

//--- verif/ascx_nbr_model.sv
// Lower neighbour slice seen through its ripple carry output
`default_nettype none
module ascx_nbr_model (
	input wire logic op_high,
	input wire logic op_mid,
	input wire logic lsb_n,
	input wire logic [3:0] opnd_a,
	input wire logic [3:0] opnd_b,
	input wire logic prop_n,
	input wire logic gen_n,
	output logic ripple_n,
	output logic la_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] sum;
	// Carry-in is active low on the op bit, so slices chain without inverters
	assign sum = {1'h0, opnd_a} + {1'h0, opnd_b} + {4'h0, ~lsb_n};
	// Arithmetic sends its carry up, any other code lets the op bit ride along
	assign ripple_n = (op_high | op_mid) ? lsb_n : ~sum[4];
	// Lookahead stage for the slice: carry = generate or propagate with carry-in, pins active low
	assign la_n = ~(~gen_n | (~prop_n & ~ripple_n));
endmodule
`default_nettype wire

//--- verif/ascx_slice_monitor.sv
// Port-level checker for the slice carry and status outputs
`default_nettype none
module ascx_slice_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [3:0] DATA_IN_N,
	input wire logic CARRY_IN_OR_OP_BIT,
	input wire logic OP_SELECT_MID,
	input wire logic OP_SELECT_HIGH,
	input wire logic TOP_SLICE_SELECT,
	input wire logic RIPPLE_CARRY_N,
	input wire logic PROPAGATE_N,
	input wire logic GENERATE_N,
	input wire logic ZERO_FLAG_O,
	input wire logic ZERO_FLAG_OE
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ar;
	logic top;
	logic cin;
	// Bus operand of all ones with carry in, or all zeros without, fixes carry whatever the stored word
	assign ar = ~OP_SELECT_HIGH & ~OP_SELECT_MID;
	assign top = TOP_SLICE_SELECT;
	assign cin = CARRY_IN_OR_OP_BIT;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	a_ripple_pass: assert property (!ar |-> RIPPLE_CARRY_N == cin)
		else $error("ripple not passing op bit");
	a_lesser_force: assert property (!ar && !top |-> !PROPAGATE_N && GENERATE_N)
		else $error("lesser slice not forced");
	a_top_noovf: assert property (!ar && top |-> GENERATE_N)
		else $error("overflow on logic op");
	a_carry_full: assert property (ar && DATA_IN_N == 4'h0 && !cin |-> !RIPPLE_CARRY_N)
		else $error("missing carry out");
	a_carry_none: assert property (ar && DATA_IN_N == 4'hF && cin |-> RIPPLE_CARRY_N)
		else $error("spurious carry out");
	a_prop_all: assert property (ar && !top && DATA_IN_N == 4'h0 |-> !PROPAGATE_N)
		else $error("propagate missing");
	a_gen_none: assert property (ar && !top && DATA_IN_N == 4'hF |-> GENERATE_N)
		else $error("spurious generate");
	a_neg_bus: assert property (top && !OP_SELECT_HIGH && OP_SELECT_MID && cin |-> PROPAGATE_N == DATA_IN_N[3])
		else $error("negative flag wrong");
	a_zero_bus: assert property (!OP_SELECT_HIGH && OP_SELECT_MID && cin |-> ZERO_FLAG_OE == (DATA_IN_N != 4'hF))
		else $error("zero flag wrong");
	a_zero_sink: assert property (ZERO_FLAG_OE |-> !ZERO_FLAG_O)
		else $error("zero pin not sinking");
	c_arith_top: cover property (ar && top);
	c_logic_low: cover property (!ar && !top);
	c_zero: cover property (ar && !ZERO_FLAG_OE);
endmodule
bind ascx_slice ascx_slice_monitor u_ascx_slice_monitor (.MCLK, .RST, .DATA_IN_N, .CARRY_IN_OR_OP_BIT,
	.OP_SELECT_MID, .OP_SELECT_HIGH, .TOP_SLICE_SELECT, .RIPPLE_CARRY_N, .PROPAGATE_N, .GENERATE_N,
	.ZERO_FLAG_O, .ZERO_FLAG_OE);
`default_nettype wire

//--- verif/ascx_slice_bench.sv
// Self-checking bench for the slice carry and status outputs
`default_nettype none
module ascx_slice_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic MCLK, RST, CARRY_IN_OR_OP_BIT, OP_SELECT_MID, OP_SELECT_HIGH, TOP_SLICE_SELECT;
	logic CLOCK_PULSE_IN, EXECUTE_GATE_N, OUTPUT_DRIVE_ENABLE_N, DATA_OUT_OE;
	logic RIPPLE_CARRY_N, PROPAGATE_N, GENERATE_N, ZERO_FLAG_O, ZERO_FLAG_OE, lsb_n, la_n;
	logic [3:0] DATA_IN_N, DATA_OUT_N, na, nb, e, st;
	logic [2:0] ADDR_SEL;
	int miscompares, cmp_count;
	// Arithmetic cases on word 1 = 5: {bus_n, carry, top, zero/ripple/prop/gen}
	logic [15:0] tab [5] = '{16'h0100, 16'h4008, 16'hC014, 16'h0113, 16'hF007};
	// Zero wire has a pull-up, so it reads high unless the slice sinks it
	assign st = {ZERO_FLAG_OE ? ZERO_FLAG_O : 1'h1, RIPPLE_CARRY_N, PROPAGATE_N, GENERATE_N};
	ascx_nbr_model u_ascx_nbr_model (.op_high(OP_SELECT_HIGH), .op_mid(OP_SELECT_MID), .lsb_n(lsb_n),
		.opnd_a(na), .opnd_b(nb), .prop_n(PROPAGATE_N), .gen_n(GENERATE_N), .ripple_n(CARRY_IN_OR_OP_BIT),
		.la_n(la_n));
	ascx_slice u_ascx_slice (.MCLK, .RST, .DATA_IN_N, .ADDR_SEL, .CARRY_IN_OR_OP_BIT, .OP_SELECT_MID,
		.OP_SELECT_HIGH, .TOP_SLICE_SELECT, .CLOCK_PULSE_IN, .EXECUTE_GATE_N, .OUTPUT_DRIVE_ENABLE_N,
		.DATA_OUT_N, .DATA_OUT_OE, .RIPPLE_CARRY_N, .PROPAGATE_N, .GENERATE_N, .ZERO_FLAG_O, .ZERO_FLAG_OE);
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [3:0] g, input logic [3:0] x);
		cmp_count++;
		if (g !== x) begin
			miscompares++;
			$display("FAIL %0t got %h want %h", $time, g, x);
		end
	endtask
	// Neighbour carries in only when its operands overflow
	task setp(input logic [3:0] dn, input logic [2:0] op, input logic t, input logic c);
		@(posedge MCLK);
		DATA_IN_N <= dn;
		OP_SELECT_HIGH <= op[2];
		OP_SELECT_MID <= op[1];
		lsb_n <= op[0];
		TOP_SLICE_SELECT <= t;
		na <= {4{c}};
		nb <= {3'h0, c};
		@(negedge MCLK);
	endtask
	// Pulse held three cycles on both phases, one past the synchroniser depth
	task commit;
		@(posedge MCLK) CLOCK_PULSE_IN <= 1'h1;
		repeat (3) @(posedge MCLK);
		CLOCK_PULSE_IN <= 1'h0;
		repeat (3) @(posedge MCLK);
		@(negedge MCLK);
	endtask
	// Logic results of word 1 = 5 against bus B
	function automatic logic [3:0] fres(input logic [2:0] op);
		case (op)
			3'h2: fres = 4'h5 & 4'hB;
			3'h3: fres = 4'hB;
			3'h4: fres = 4'h5;
			3'h5: fres = 4'h5 | 4'hB;
			3'h6: fres = 4'h5 ^ 4'hB;
			default: fres = ~4'hB;
		endcase
	endfunction
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		MCLK = 1'h0;
		forever #5 MCLK = ~MCLK;
	end
	// A run needs well under a thousand cycles
	initial begin
		#20000;
		miscompares++;
		print_verdict();
	end
	initial begin
		{RST, OP_SELECT_MID, lsb_n, EXECUTE_GATE_N, OUTPUT_DRIVE_ENABLE_N} = 5'h18;
		{OP_SELECT_HIGH, TOP_SLICE_SELECT, CLOCK_PULSE_IN} = 3'h0;
		DATA_IN_N = 4'hA;
		ADDR_SEL = 3'h1;
		na = 4'h0;
		nb = 4'h0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(posedge MCLK);
		RST <= 1'h0;
		@(negedge MCLK);
		chk(DATA_OUT_N, 4'hF);
		setp(4'hA, 3'h3, 1'h0, 1'h0);
		commit();
		chk(DATA_OUT_N, 4'hA);
		chk({3'h0, DATA_OUT_OE}, 4'h1);
		$display("load test done");
		foreach (tab[i]) begin
			setp(tab[i][15:12], 3'h1, tab[i][4], tab[i][8]);
			chk(st, tab[i][3:0]);
			if (!tab[i][4]) chk({3'h0, la_n}, {3'h0, tab[i][2]});
		end
		$display("arith test done");
		// Clock pulse and execute held high: outputs must still follow
		@(posedge MCLK);
		EXECUTE_GATE_N <= 1'h1;
		CLOCK_PULSE_IN <= 1'h1;
		for (int o = 2; o < 8; o++) begin
			for (int t = 0; t < 2; t++) begin
				setp(4'h4, o[2:0], t[0], 1'h0);
				e = fres(o[2:0]);
				chk(st, {1'h0, o[0], t[0] ? ~e[3] : 1'h0, 1'h1});
				if (!t[0]) chk({3'h0, la_n}, {3'h0, o[0]});
			end
		end
		// Execute held high: the pulse must not have loaded the output register
		chk(DATA_OUT_N, 4'hA);
		$display("logic test done");
		print_verdict();
	end
endmodule
`default_nettype wire
